/* rtl/psau_pkg.sv */
/*
 * Shared constants and types for the program space access unit.
 * Assumes a 24-bit wide program memory and a 16-bit core datapath.
 */
package psau_pkg;

  // Program space geometry.
  localparam int unsigned PADDR_W = 24;
  localparam int unsigned PWORD_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned PC_W = 23;
  localparam int unsigned PSPACE_WORDS = 4194304;
  localparam logic [23:0] USER_TOP = 24'h7ffffe;

  // Field positions.
  localparam int unsigned EA_MSB = 15;
  localparam int unsigned CFG_BIT = 7;
  localparam int unsigned CTRL_VIS_BIT = 0;

  // Register map, byte addresses on the APB.
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFS_TPAGE = 8'h00;
  localparam logic [7:0] OFS_VPAGE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_LADDR = 8'h0c;
  localparam logic [7:0] OFS_LDATA = 8'h10;

  // Reset values.
  localparam logic [7:0] TPAGE_RST = 8'h00;
  localparam logic [7:0] VPAGE_RST = 8'h00;
  localparam logic VIS_RST = 1'b0;

  // Cycles from request taken to answer, with the clock enable high.
  localparam int unsigned RSP_LAT = 3;

  typedef enum logic [2:0] {
    PSAU_OP_FETCH,
    PSAU_OP_DATA_RD,
    PSAU_OP_TRD_LOW,
    PSAU_OP_TRD_HIGH,
    PSAU_OP_TWR_LOW,
    PSAU_OP_TWR_HIGH
  } psau_op_t;

  typedef enum logic [1:0] {
    PSAU_ST_IDLE,
    PSAU_ST_ISSUE,
    PSAU_ST_CAPTURE
  } psau_state_t;

  typedef struct packed {
    psau_op_t op;
    logic byte_mode;
    logic [15:0] ea;
    logic [22:0] pc;
    logic [15:0] wdata;
  } psau_req_t;

  typedef struct packed {
    logic [23:0] addr;
    logic rd;
    logic wr;
    logic [2:0] be;
    logic [23:0] wdata;
  } psau_pm_t;

  typedef struct packed {
    logic [15:0] data;
    logic [23:0] instr;
    logic redirected;
    logic cfg;
  } psau_rsp_t;

endpackage : psau_pkg

/* rtl/psau_top.sv */
/*
 * Program space access unit: forms 24-bit program addresses for fetch,
 * table and visibility-window accesses, and maps program words onto data.
 * Assumes a program memory that samples the request at a clock edge and
 * returns read data during the following cycle, under the same enable.
 */
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Functional notes
// - Program space holds 4M words behind a 24-bit address.
// - Consecutive program words are two address units apart.
// - Non-table accesses stay within 0x000000 to 0x7fffff; fetches stay within 0x7ffffe.
// - Table page bit 7 picks user or configuration space.
// - Address bit 23 is set only by configuration table accesses.
// - Fetch address is zero bit 23, program counter bits 22 to 1, and a zero bit 0.
// - Table address is table page over the full effective address.
// - Window address is zero, visibility page, effective address low 15.
// - Program word is 24 bits: low word space and high byte space.
// - Low table read, word mode, returns program bits 15 to 0.
// - Low table read, byte mode, returns low or high byte by select.
// - High table read, word mode, returns zero-extended bits 23 to 16.
// - High table read, byte mode, select one yields a zero byte.
// - Upper program byte reaches data only through high table operations.
// - Low table operations reach the low word without data mapping.
// - One 16K-word page may be seen in upper data space.
// - Redirect only when effective address bit 15 and visibility enable set.
// - Visibility page is eight bits and supplies address bits 22 to 15.
// - Window redirection is suspended during table reads and writes.
module psau_top (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [psau_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic REQ_VALID_I,
  input wire psau_pkg::psau_req_t REQ_I,
  output logic REQ_READY_O,
  output logic RSP_VALID_O,
  output psau_pkg::psau_rsp_t RSP_O,
  output psau_pkg::psau_pm_t PM_O,
  input wire logic [psau_pkg::PWORD_W-1:0] PM_RDATA_I
);

  logic [psau_pkg::PAGE_W-1:0] tpage;
  logic [psau_pkg::PAGE_W-1:0] vpage;
  logic vis_en;
  logic [psau_pkg::PADDR_W-1:0] last_addr;
  logic [psau_pkg::DATA_W-1:0] last_data;
  psau_pkg::psau_state_t state;
  psau_pkg::psau_req_t req_q;
  logic redir_q;
  logic req_take;
  logic next_redir;
  psau_pkg::psau_pm_t next_pm;
  psau_pkg::psau_rsp_t next_rsp;
  logic [31:0] rd_mux;
  logic mapped;
  logic read_only;
  logic apb_wr;

  // Register bus. The slave never stretches a transfer except while the
  // enable is low, so that a frozen unit cannot lose a write.
  assign PREADY_O = CE_I;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I & CE_I & mapped & ~read_only;
  assign PSLVERR_O = PSEL_I & PENABLE_I & (~mapped | (PWRITE_I & read_only));

  always_comb begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    read_only = 1'b0;
    unique case (PADDR_I)
      psau_pkg::OFS_TPAGE: rd_mux = {24'h000000, tpage};
      psau_pkg::OFS_VPAGE: rd_mux = {24'h000000, vpage};
      psau_pkg::OFS_CTRL: rd_mux = {31'h0, vis_en};
      psau_pkg::OFS_LADDR: begin
        rd_mux = {8'h00, last_addr};
        read_only = 1'b1;
      end
      psau_pkg::OFS_LDATA: begin
        rd_mux = {16'h0000, last_data};
        read_only = 1'b1;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data is latched in the setup cycle so that it comes from a flop.
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (CE_I && PSEL_I && !PENABLE_I) begin
      PRDATA_O <= rd_mux;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tpage <= psau_pkg::TPAGE_RST;
      vpage <= psau_pkg::VPAGE_RST;
      vis_en <= psau_pkg::VIS_RST;
    end else if (apb_wr) begin
      if (PADDR_I == psau_pkg::OFS_TPAGE) begin
        tpage <= PWDATA_I[7:0];
      end
      if (PADDR_I == psau_pkg::OFS_VPAGE) begin
        vpage <= PWDATA_I[7:0];
      end
      if (PADDR_I == psau_pkg::OFS_CTRL) begin
        vis_en <= PWDATA_I[psau_pkg::CTRL_VIS_BIT];
      end
    end
  end

  // Core request side.
  assign REQ_READY_O = CE_I & (state == psau_pkg::PSAU_ST_IDLE);
  assign req_take = REQ_VALID_I & REQ_READY_O;

  always_comb begin
    next_pm = '0;
    next_redir = REQ_I.ea[psau_pkg::EA_MSB] & vis_en;
    unique case (REQ_I.op)
      psau_pkg::PSAU_OP_FETCH: begin
        next_pm.addr = {1'b0, REQ_I.pc[22:1], 1'b0};
        next_pm.rd = 1'b1;
      end
      psau_pkg::PSAU_OP_DATA_RD: begin
        // Only a plain data read can be redirected; table operations never
        // take this path, which keeps the window off during them.
        next_pm.addr = {1'b0, vpage, REQ_I.ea[14:0]};
        next_pm.rd = next_redir;
      end
      psau_pkg::PSAU_OP_TRD_LOW, psau_pkg::PSAU_OP_TRD_HIGH: begin
        next_pm.addr = {tpage, REQ_I.ea};
        next_pm.rd = 1'b1;
      end
      psau_pkg::PSAU_OP_TWR_LOW: begin
        next_pm.addr = {tpage, REQ_I.ea};
        next_pm.wr = 1'b1;
        if (REQ_I.byte_mode) begin
          next_pm.wdata = {8'h00, REQ_I.wdata[7:0], REQ_I.wdata[7:0]};
          next_pm.be = REQ_I.ea[0] ? 3'h2 : 3'h1;
        end else begin
          next_pm.wdata = {8'h00, REQ_I.wdata};
          next_pm.be = 3'h3;
        end
      end
      psau_pkg::PSAU_OP_TWR_HIGH: begin
        next_pm.addr = {tpage, REQ_I.ea};
        next_pm.wr = 1'b1;
        next_pm.wdata = {REQ_I.wdata[7:0], 16'h0000};
        // The byte above the high byte does not exist, so it writes nothing.
        next_pm.be = (REQ_I.byte_mode && REQ_I.ea[0]) ? 3'h0 : 3'h4;
      end
      default: begin
        next_pm = '0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= psau_pkg::PSAU_ST_IDLE;
    end else if (CE_I) begin
      unique case (state)
        psau_pkg::PSAU_ST_IDLE: begin
          if (req_take) begin
            state <= psau_pkg::PSAU_ST_ISSUE;
          end
        end
        psau_pkg::PSAU_ST_ISSUE: state <= psau_pkg::PSAU_ST_CAPTURE;
        psau_pkg::PSAU_ST_CAPTURE: state <= psau_pkg::PSAU_ST_IDLE;
        default: state <= psau_pkg::PSAU_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      req_q <= '0;
      redir_q <= 1'b0;
    end else if (CE_I && req_take) begin
      req_q <= REQ_I;
      redir_q <= next_redir & (REQ_I.op == psau_pkg::PSAU_OP_DATA_RD);
    end
  end

  // Strobes last one enabled cycle; the address stays for observation.
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PM_O <= '0;
    end else if (CE_I) begin
      if (req_take) begin
        PM_O <= next_pm;
      end else begin
        PM_O.rd <= 1'b0;
        PM_O.wr <= 1'b0;
        PM_O.be <= 3'h0;
      end
    end
  end

  // Word-to-data mapping of the fetched 24-bit program word.
  always_comb begin
    next_rsp = '0;
    next_rsp.cfg = PM_O.addr[psau_pkg::PADDR_W-1];
    unique case (req_q.op)
      psau_pkg::PSAU_OP_FETCH: next_rsp.instr = PM_RDATA_I;
      psau_pkg::PSAU_OP_DATA_RD: begin
        next_rsp.redirected = redir_q;
        if (redir_q) begin
          next_rsp.data = PM_RDATA_I[15:0];
        end
      end
      psau_pkg::PSAU_OP_TRD_LOW: begin
        if (!req_q.byte_mode) begin
          next_rsp.data = PM_RDATA_I[15:0];
        end else if (req_q.ea[0]) begin
          next_rsp.data = {8'h00, PM_RDATA_I[15:8]};
        end else begin
          next_rsp.data = {8'h00, PM_RDATA_I[7:0]};
        end
      end
      psau_pkg::PSAU_OP_TRD_HIGH: begin
        if (req_q.byte_mode && req_q.ea[0]) begin
          next_rsp.data = 16'h0000;
        end else begin
          next_rsp.data = {8'h00, PM_RDATA_I[23:16]};
        end
      end
      default: next_rsp.data = 16'h0000;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_O <= '0;
    end else if (CE_I) begin
      RSP_VALID_O <= (state == psau_pkg::PSAU_ST_CAPTURE);
      if (state == psau_pkg::PSAU_ST_CAPTURE) begin
        RSP_O <= next_rsp;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      last_addr <= 24'h000000;
      last_data <= 16'h0000;
    end else if (CE_I && state == psau_pkg::PSAU_ST_CAPTURE) begin
      last_addr <= PM_O.addr;
      last_data <= next_rsp.data;
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESETN_I);

  logic pm_act;
  assign pm_act = PM_O.rd | PM_O.wr;

  fetch_addr_a: assert property (
    state == psau_pkg::PSAU_ST_ISSUE && req_q.op == psau_pkg::PSAU_OP_FETCH
    |-> PM_O.rd && PM_O.addr == {1'b0, req_q.pc[22:1], 1'b0})
    else $error("fetch address not formed from program counter");

  user_range_a: assert property (
    pm_act && req_q.op inside {psau_pkg::PSAU_OP_FETCH, psau_pkg::PSAU_OP_DATA_RD}
    |-> {PM_O.addr[23:1], 1'b0} <= psau_pkg::USER_TOP
        && (req_q.op == psau_pkg::PSAU_OP_DATA_RD || !PM_O.addr[0]))
    else $error("non-table access outside user range");

  cfg_bit_a: assert property (
    pm_act && PM_O.addr[23]
    |-> req_q.op inside {psau_pkg::PSAU_OP_TRD_LOW, psau_pkg::PSAU_OP_TRD_HIGH,
                         psau_pkg::PSAU_OP_TWR_LOW, psau_pkg::PSAU_OP_TWR_HIGH})
    else $error("bit 23 set outside a table access");

  table_addr_a: assert property (
    req_take && REQ_I.op inside {psau_pkg::PSAU_OP_TRD_LOW, psau_pkg::PSAU_OP_TRD_HIGH,
                                 psau_pkg::PSAU_OP_TWR_LOW, psau_pkg::PSAU_OP_TWR_HIGH}
    |=> pm_act && PM_O.addr == {$past(tpage), $past(REQ_I.ea)})
    else $error("table address not page over effective address");

  window_addr_a: assert property (
    req_take && REQ_I.op == psau_pkg::PSAU_OP_DATA_RD && REQ_I.ea[15] && vis_en
    |=> PM_O.rd && PM_O.addr == {1'b0, $past(vpage), $past(REQ_I.ea[14:0])})
    else $error("window address wrong");

  no_redirect_a: assert property (
    req_take && REQ_I.op == psau_pkg::PSAU_OP_DATA_RD && !(REQ_I.ea[15] && vis_en)
    ##1 CE_I [*2] |=> !RSP_O.redirected && !$past(PM_O.rd, 2))
    else $error("data access redirected without cause");

  low_word_a: assert property (
    CE_I && state == psau_pkg::PSAU_ST_CAPTURE && req_q.op == psau_pkg::PSAU_OP_TRD_LOW
    && !req_q.byte_mode |=> RSP_VALID_O && RSP_O.data == $past(PM_RDATA_I[15:0]))
    else $error("low word read mapping wrong");

  low_byte_a: assert property (
    CE_I && state == psau_pkg::PSAU_ST_CAPTURE && req_q.op == psau_pkg::PSAU_OP_TRD_LOW
    && req_q.byte_mode && req_q.ea[0] |=> RSP_O.data == {8'h00, $past(PM_RDATA_I[15:8])})
    else $error("low byte read mapping wrong");

  low_byte_even_a: assert property (
    CE_I && state == psau_pkg::PSAU_ST_CAPTURE && req_q.op == psau_pkg::PSAU_OP_TRD_LOW
    && req_q.byte_mode && !req_q.ea[0] |=> RSP_O.data == {8'h00, $past(PM_RDATA_I[7:0])})
    else $error("low byte read mapping wrong for select zero");

  high_word_a: assert property (
    CE_I && state == psau_pkg::PSAU_ST_CAPTURE && req_q.op == psau_pkg::PSAU_OP_TRD_HIGH
    && !req_q.byte_mode |=> RSP_O.data == {8'h00, $past(PM_RDATA_I[23:16])})
    else $error("high word read mapping wrong");

  phantom_byte_a: assert property (
    CE_I && state == psau_pkg::PSAU_ST_CAPTURE && req_q.op == psau_pkg::PSAU_OP_TRD_HIGH
    && req_q.byte_mode && req_q.ea[0] |=> RSP_VALID_O && RSP_O.data == 16'h0000)
    else $error("phantom high byte not zero");

  window_low_a: assert property (
    CE_I && state == psau_pkg::PSAU_ST_CAPTURE && req_q.op == psau_pkg::PSAU_OP_DATA_RD
    |=> RSP_O.data == (RSP_O.redirected ? $past(PM_RDATA_I[15:0]) : 16'h0000))
    else $error("window read exposed the upper byte");

  // A frozen unit must not move, or a memory strobe would be lost or doubled.
  freeze_hold_a: assert property (
    !CE_I |=> $stable(state) && $stable(PM_O) && $stable(RSP_VALID_O))
    else $error("state moved while the clock enable was low");

  answer_time_a: assert property (
    req_take ##1 CE_I [*2] |=> RSP_VALID_O)
    else $error("answer not three cycles after the request");

  fetch_c: cover property (RSP_VALID_O && req_q.op == psau_pkg::PSAU_OP_FETCH);
  cfg_read_c: cover property (RSP_VALID_O && RSP_O.cfg);
  window_c: cover property (RSP_VALID_O && RSP_O.redirected);
  high_write_c: cover property (PM_O.wr && PM_O.be == 3'h4);
  no_window_c: cover property (
    RSP_VALID_O && req_q.op == psau_pkg::PSAU_OP_DATA_RD && !RSP_O.redirected);

endmodule : psau_top

/* tb/psau_pmem_model.sv */
/*
 * Behavioural model of the 24-bit program memory behind the access unit.
 * Assumes the unit strobes rd or wr with the address for one enabled cycle
 * and expects read data during the following cycle, under the same enable.
 */
`timescale 1ns/1ps
module psau_pmem_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire psau_pkg::psau_pm_t pm_i,
  output logic [23:0] rdata_o
);
  logic [23:0] mem [logic [22:0]];
  logic [23:0] w;

  // Unwritten words hold a pattern derived from the word address.
  function automatic logic [23:0] pat(input logic [23:0] a);
    return {a[8:1] ^ 8'h5a, a[16:1] ^ 16'hc3a5};
  endfunction : pat

  // Outside a read cycle the data lines toggle, so a late capture is seen.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 24'h5a5a5a;
    end else if (ce_i) begin
      w = mem.exists(pm_i.addr[23:1]) ? mem[pm_i.addr[23:1]] : pat(pm_i.addr);
      if (pm_i.rd) begin
        rdata_o <= w;
      end else begin
        rdata_o <= ~rdata_o;
      end
      if (pm_i.wr) begin
        for (int b = 0; b < 3; b++) begin
          if (pm_i.be[b]) begin
            w[8*b +: 8] = pm_i.wdata[8*b +: 8];
          end
        end
        mem[pm_i.addr[23:1]] = w;
      end
    end
  end
endmodule : psau_pmem_model

/* tb/psau_top_tb.sv */
/*
 * Self-checking bench for the program space access unit.
 * Assumes the memory model above and the register map of the package.
 */
`timescale 1ns/1ps
module psau_top_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid = 1'b0;
  psau_pkg::psau_req_t req = '0;
  logic req_ready;
  logic rsp_valid;
  psau_pkg::psau_rsp_t rsp_o;
  psau_pkg::psau_rsp_t rsp;
  psau_pkg::psau_pm_t pm;
  psau_pkg::psau_pm_t pmc;
  logic [23:0] pm_rdata;
  logic [31:0] rd_val;
  logic rd_err;
  logic pm_seen;
  int lat;
  int n_fail = 0;
  int total_checks = 0;

  psau_top psau_top_i (.CLOCK_I(clock), .RESETN_I(resetn), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .REQ_VALID_I(req_valid),
    .REQ_I(req), .REQ_READY_O(req_ready), .RSP_VALID_O(rsp_valid), .RSP_O(rsp_o),
    .PM_O(pm), .PM_RDATA_I(pm_rdata));
  psau_pmem_model psau_pmem_model_i (.clk_i(clock), .rstn_i(resetn), .ce_i(ce),
    .pm_i(pm), .rdata_o(pm_rdata));

  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic hang();
    n_fail++;
    $display("ERROR t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    results();
  endtask : hang

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 50) hang();
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic core(input psau_pkg::psau_op_t op, input logic bm, input logic [15:0] ea,
                      input logic [22:0] pc, input logic [15:0] wd);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, byte_mode: bm, ea: ea, pc: pc, wdata: wd};
    pm_seen = 1'b0;
    pmc = '0;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    if (n == 50) hang();
    req_valid <= 1'b0;
    for (lat = 1; lat < 50; lat++) begin
      @(negedge clock);
      if (pm.rd === 1'b1 || pm.wr === 1'b1) begin
        pmc = pm;
        pm_seen = 1'b1;
      end
      if (rsp_valid === 1'b1) break;
    end
    if (lat == 50) hang();
    rsp = rsp_o;
  endtask : core

  initial begin
    logic [22:0] pcs [2];
    logic [7:0] tps [2];
    logic [23:0] a;
    logic [23:0] w;
    logic [15:0] e;
    logic [15:0] ea;
    int j;
    pcs = '{23'h2b3c4d, 23'h7fffff};
    tps = '{8'h12, 8'h81};
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, psau_pkg::OFS_TPAGE, 32'h0);
    chk(rd_val, 32'(psau_pkg::TPAGE_RST));
    apb(1'b0, psau_pkg::OFS_VPAGE, 32'h0);
    chk(rd_val, 32'(psau_pkg::VPAGE_RST));
    apb(1'b0, psau_pkg::OFS_CTRL, 32'h0);
    chk(rd_val, 32'(psau_pkg::VIS_RST));
    apb(1'b1, psau_pkg::OFS_VPAGE, 32'hffff_ff3c);
    apb(1'b0, psau_pkg::OFS_VPAGE, 32'h0);
    chk(rd_val, 32'h3c);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rd_err), 32'h1);
    apb(1'b1, psau_pkg::OFS_LADDR, 32'h1234);
    chk(32'(rd_err), 32'h1);
    @(posedge clock);
    ce <= 1'b0;
    @(negedge clock);
    chk(32'({pready, req_ready}), 32'h0);
    @(posedge clock);
    ce <= 1'b1;
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      core(psau_pkg::PSAU_OP_FETCH, 1'b0, 16'hffff, pcs[i], 16'h0);
      a = {1'b0, pcs[i][22:1], 1'b0};
      chk(32'(pmc.addr), 32'(a));
      chk(32'(rsp.instr), 32'(psau_pmem_model_i.pat(a)));
      chk(32'(rsp.cfg), 32'h0);
      chk(32'(lat), 32'(psau_pkg::RSP_LAT));
      apb(1'b0, psau_pkg::OFS_LADDR, 32'h0);
      chk(rd_val, 32'(a));
    end
    $display("test fetch done");
    // Word reads use an odd address to show that the byte select is ignored.
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, psau_pkg::OFS_TPAGE, 32'(tps[t]));
      for (int i = 0; i < 6; i++) begin
        j = i % 3;
        ea = {15'h2536, j != 1};
        a = {tps[t], ea};
        w = psau_pmem_model_i.pat(a);
        if (i < 3) begin
          e = (j == 0) ? w[15:0] : (j == 1) ? {8'h0, w[7:0]} : {8'h0, w[15:8]};
        end else begin
          e = (j == 2) ? 16'h0 : {8'h0, w[23:16]};
        end
        core((i < 3) ? psau_pkg::PSAU_OP_TRD_LOW : psau_pkg::PSAU_OP_TRD_HIGH,
             j != 0, ea, 23'h0, 16'h0);
        chk(32'(pmc.addr), 32'(a));
        chk(32'(rsp.data), 32'(e));
        chk(32'({rsp.cfg, rsp.redirected}), 32'({tps[t][7], 1'b0}));
      end
      apb(1'b0, psau_pkg::OFS_LDATA, 32'h0);
      chk(rd_val, 32'(e));
    end
    $display("test table reads done");
    apb(1'b1, psau_pkg::OFS_VPAGE, 32'hab);
    apb(1'b1, psau_pkg::OFS_CTRL, 32'h1);
    core(psau_pkg::PSAU_OP_DATA_RD, 1'b0, 16'hc123, 23'h0, 16'h0);
    a = {1'b0, 8'hab, 15'h4123};
    chk(32'(pmc.addr), 32'(a));
    w = psau_pmem_model_i.pat(a);
    chk(32'({rsp.redirected, rsp.cfg, rsp.data}), 32'({2'b10, w[15:0]}));
    core(psau_pkg::PSAU_OP_DATA_RD, 1'b0, 16'h4123, 23'h0, 16'h0);
    chk(32'({pm_seen, rsp.redirected, rsp.data}), 32'h0);
    core(psau_pkg::PSAU_OP_TRD_LOW, 1'b0, 16'h8000, 23'h0, 16'h0);
    chk(32'({rsp.redirected, pmc.addr}), 32'h818000);
    apb(1'b1, psau_pkg::OFS_CTRL, 32'h0);
    core(psau_pkg::PSAU_OP_DATA_RD, 1'b0, 16'hc123, 23'h0, 16'h0);
    chk(32'({pm_seen, rsp.redirected}), 32'h0);
    $display("test window done");
    apb(1'b1, psau_pkg::OFS_TPAGE, 32'h12);
    core(psau_pkg::PSAU_OP_TWR_LOW, 1'b0, 16'h0200, 23'h0, 16'hbeef);
    chk(32'({pmc.addr, 5'h0, pmc.be}), 32'h12020003);
    chk(32'(rsp.data), 32'h0);
    core(psau_pkg::PSAU_OP_TWR_LOW, 1'b1, 16'h0201, 23'h0, 16'h00cd);
    chk(32'(pmc.be), 32'h2);
    core(psau_pkg::PSAU_OP_TRD_LOW, 1'b0, 16'h0200, 23'h0, 16'h0);
    chk(32'(rsp.data), 32'hcdef);
    core(psau_pkg::PSAU_OP_TWR_HIGH, 1'b1, 16'h0201, 23'h0, 16'h0033);
    chk(32'(pmc.be), 32'h0);
    core(psau_pkg::PSAU_OP_TWR_HIGH, 1'b0, 16'h0200, 23'h0, 16'h0077);
    chk(32'(pmc.be), 32'h4);
    core(psau_pkg::PSAU_OP_TRD_HIGH, 1'b0, 16'h0201, 23'h0, 16'h0);
    chk(32'(rsp.data), 32'h0077);
    $display("test table writes done");
    results();
  end
endmodule : psau_top_tb
